// ---- logic/ast_pkg.sv ----
// What this block does
// [R1] enabled and nothing pending: serial line held high
// [R2] disabled: output enable dropped so the pin returns to port use
// [R3] frame is start bit, 8 or 9 data bits LSB first, stop bit
// [R4] start bit drives the line low
// [R5] idle character is 10 or 11 bit times of high level
// [R6] word-length select picks 9 bits, ninth bit from its own control
// [R7] enabling sends a preamble of 10 or 11 ones first
// [R8] empty flag cleared only by status access then data write
// [R9] empty flag set when buffer empties as a transfer starts; masked interrupt
// [R10] write during shifting waits in buffer, moved in at character end
// [R11] write while idle loads shifter at once and sets empty flag
// [R12] complete flag set after stop bit; masked interrupt
// [R13] complete flag cleared by same status-then-write sequence
// [R14] send-break loads break characters, repeated while set
// [R15] after break released, one high bit is appended
// [R16] enable toggled mid-frame: preamble after current word, stop bit excluded; the code sends the stop bit before the preamble
// [R17] toggling enable discards buffered data
// [R18] bit rate is clock / (16 * coarse prescaler * power-of-two divider)
// [R19] nonzero extended prescaler further divides the 16x clock; zero bypasses
// [R20] software keeps baud settings still while enabled
// [R21] break holds line low a full frame before the high bit
package ast_pkg;

    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;

    // last index counters for bits within a word and within a frame
    localparam logic [3:0] WORD8_LAST = 4'h7;
    localparam logic [3:0] WORD9_LAST = 4'h8;
    localparam logic [3:0] FRAME8_LAST = 4'h9;
    localparam logic [3:0] FRAME9_LAST = 4'hA;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    // 16x oversampling stage and coarse prescaler terminal counts
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] PR1_LAST = 4'h0;
    localparam logic [3:0] PR3_LAST = 4'h2;
    localparam logic [3:0] PR4_LAST = 4'h3;
    localparam logic [3:0] PR13_LAST = 4'hC;
    localparam logic [1:0] PR_SEL_1 = 2'h0;
    localparam logic [1:0] PR_SEL_3 = 2'h1;
    localparam logic [1:0] PR_SEL_4 = 2'h2;
    localparam logic [7:0] EXT_OFF = 8'h00;

    localparam logic [1:0] CPU_MASK_OPEN = 2'h0;
    localparam logic TX_BUFFER_EMPTY_FLAG_RST = 1'h1;
    localparam logic TC_RST = 1'h1;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_IDLE = 3'b001,
        ST_PRE = 3'b010,
        ST_START = 3'b011,
        ST_DATA = 3'b100,
        ST_STOP = 3'b101,
        ST_BREAK = 3'b110,
        ST_MARK = 3'b111
    } ast_state_t;

endpackage

// ---- logic/ast_baud_gen.sv ----
`timescale 1ns/1ps
module ast_baud_gen
    import ast_pkg::*;
(
    input wire logic ref_clk_i, // system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic run_i, // counters held at zero while low
    input wire logic [1:0] pr_sel_i, // coarse prescaler select
    input wire logic [2:0] tr_sel_i, // power-of-two divider select
    input wire logic [7:0] ext_i, // extended prescaler, zero = bypass
    output logic tick_o // one-cycle pulse per bit time
);

    typedef struct packed {
        logic [3:0] pr_cnt;
        logic [3:0] os_cnt;
        logic [7:0] ext_cnt;
        logic [6:0] tr_cnt;
        logic tick;
    } ast_baud_state_t;

    ast_baud_state_t state_reg;
    ast_baud_state_t state_next;
    logic [3:0] pr_last;
    logic [7:0] ext_last;
    logic [6:0] tr_last;

    always_comb
    begin
        unique case (pr_sel_i)
            PR_SEL_1: pr_last = PR1_LAST;
            PR_SEL_3: pr_last = PR3_LAST;
            PR_SEL_4: pr_last = PR4_LAST;
            default: pr_last = PR13_LAST;
        endcase
        ext_last = (ext_i == EXT_OFF) ? EXT_OFF : ext_i - 8'h01; // R19
        tr_last = 7'((8'h01 << tr_sel_i) - 8'h01);
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run_i)
        begin
            state_next = '0;
        end
        else if (state_reg.pr_cnt != pr_last)
        begin
            state_next.pr_cnt = state_reg.pr_cnt + 4'h1;
        end
        else
        begin
            // cascade: prescaler, 16x stage, extended stage, divider
            state_next.pr_cnt = CNT_ZERO; // R18
            if (state_reg.os_cnt != OVS_LAST)
            begin
                state_next.os_cnt = state_reg.os_cnt + 4'h1;
            end
            else
            begin
                state_next.os_cnt = CNT_ZERO;
                if (state_reg.ext_cnt != ext_last)
                begin
                    state_next.ext_cnt = state_reg.ext_cnt + 8'h01; // R19
                end
                else
                begin
                    state_next.ext_cnt = EXT_OFF;
                    if (state_reg.tr_cnt != tr_last)
                    begin
                        state_next.tr_cnt = state_reg.tr_cnt + 7'h01;
                    end
                    else
                    begin
                        state_next.tr_cnt = 7'h00; // R18
                        state_next.tick = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign tick_o = state_reg.tick;

endmodule

// ---- logic/ast_fifo.sv ----
`timescale 1ns/1ps
module ast_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk_i, // system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic flush_i, // drop all contents
    input wire logic in_valid_i, // write request
    output logic in_ready_o, // space available
    input wire logic [WIDTH-1:0] in_data_i, // write data
    output logic out_valid_o, // a word is waiting
    input wire logic out_ready_i, // consumer takes the word
    output logic [WIDTH-1:0] out_data_o, // oldest word
    output logic out_last_o // exactly one word left
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic in_rdy;
        logic out_vld;
        logic last;
    } ast_fifo_state_t;

    ast_fifo_state_t state_reg;
    ast_fifo_state_t state_next;
    logic push;
    logic pop;

    always_comb
    begin
        push = in_valid_i && state_reg.in_rdy;
        pop = out_ready_i && state_reg.out_vld;
        state_next = state_reg;
        if (flush_i)
        begin
            state_next.wr_ptr = '0;
            state_next.rd_ptr = '0;
            state_next.count = '0;
        end
        else
        begin
            if (push)
            begin
                state_next.mem[state_reg.wr_ptr] = in_data_i;
                state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
            end
            if (pop)
                state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
            if (push && !pop)
                state_next.count = state_reg.count + 1'b1;
            else if (pop && !push)
                state_next.count = state_reg.count - 1'b1;
        end
        // flags registered so the ports come straight from flops
        state_next.in_rdy = state_next.count != (AW+1)'(DEPTH);
        state_next.out_vld = state_next.count != '0;
        state_next.last = state_next.count == (AW+1)'(1);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= '0;
            state_reg.in_rdy <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign in_ready_o = state_reg.in_rdy;
    assign out_valid_o = state_reg.out_vld;
    assign out_data_o = state_reg.mem[state_reg.rd_ptr];
    assign out_last_o = state_reg.last;

endmodule

// ---- logic/ast_tx.sv ----
`timescale 1ns/1ps
module ast_tx
    import ast_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk_i, // 250 MHz system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic tx_enable_i, // transmitter enable
    input wire logic word9_sel_i, // 1 = 9-bit words
    input wire logic tx_ninth_bit_i, // ninth data bit
    input wire logic send_break_ctl_i, // send break characters
    input wire logic tx_empty_irq_en_i, // empty interrupt enable
    input wire logic tx_complete_irq_en_i, // complete interrupt enable
    input wire logic [1:0] cpu_condition_codes_i, // cpu interrupt mask bits
    input wire logic serial_status_port_rd_i, // status access pulse
    input wire logic serial_data_port_wr_i, // data write pulse
    input wire logic [7:0] serial_data_port_i, // data written
    input wire logic [1:0] baud_select_pr_i, // coarse prescaler select
    input wire logic [2:0] baud_select_tr_i, // transmit divider select
    input wire logic [7:0] tx_ext_prescaler_i, // extended prescaler
    output logic serial_tx_o, // serial line level
    output logic serial_tx_oe_o, // high while block drives the pin
    output logic data_ready_o, // holding buffer has room
    output logic tx_buffer_empty_flag_o, // buffer empty flag
    output logic tx_complete_flag_o, // transmission complete flag
    output logic irq_o // interrupt request
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        ast_state_t st;
        logic [8:0] shift;
        logic [3:0] cnt;
        logic line;
        logic oe;
        logic en_prev;
        logic pre_pend;
        logic seen;
        logic tx_buffer_empty_flag;
        logic tc;
        logic irq;
    } ast_tx_state_t;

    ast_tx_state_t state_reg;
    ast_tx_state_t state_next;

    logic tick;
    logic baud_run;
    logic en_rise;
    logic en_fall;
    logic flush;
    logic end_frame;
    logic load;
    logic set_tx_buffer_empty_flag;
    logic set_tc;
    logic clear_seq;
    logic [3:0] frame_last;
    logic [3:0] word_last;
    logic fifo_valid;
    logic fifo_last;
    logic fifo_ready;
    logic [8:0] fifo_data;

    // ****************************************
    // baud generator and holding buffer
    // ****************************************
    // divider idles at zero so the first bit after idle is a full bit time
    assign baud_run = (state_reg.st != ST_OFF) && (state_reg.st != ST_IDLE);

    ast_baud_gen u_baud (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .run_i(baud_run),
        .pr_sel_i(baud_select_pr_i),
        .tr_sel_i(baud_select_tr_i),
        .ext_i(tx_ext_prescaler_i),
        .tick_o(tick)
    );

    // writes are taken only while enabled; toggling enable flushes
    ast_fifo #(
        .WIDTH(DATA_W + 1),
        .DEPTH(DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .flush_i(flush),
        .in_valid_i(serial_data_port_wr_i && tx_enable_i),
        .in_ready_o(fifo_ready),
        .in_data_i({tx_ninth_bit_i, serial_data_port_i}),
        .out_valid_o(fifo_valid),
        .out_ready_i(load),
        .out_data_o(fifo_data),
        .out_last_o(fifo_last)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        frame_last = word9_sel_i ? FRAME9_LAST : FRAME8_LAST; // R5
        word_last = word9_sel_i ? WORD9_LAST : WORD8_LAST; // R6
        en_rise = tx_enable_i && !state_reg.en_prev;
        en_fall = !tx_enable_i && state_reg.en_prev;
        flush = en_rise || en_fall; // R17
        end_frame = 1'b0;
        load = 1'b0;
        set_tx_buffer_empty_flag = 1'b0;
        set_tc = 1'b0;
        state_next.en_prev = tx_enable_i;

        // re-enable during a frame defers the preamble to its end
        if (en_rise && state_reg.st != ST_OFF)
            state_next.pre_pend = 1'b1; // R16

        unique case (state_reg.st)
            ST_OFF:
            begin
                if (en_rise)
                begin
                    state_next.st = ST_PRE; // R7
                    state_next.cnt = CNT_ZERO;
                    state_next.pre_pend = 1'b0;
                end
            end
            ST_IDLE:
            begin
                end_frame = 1'b1;
            end
            ST_PRE:
            begin
                if (tick)
                begin
                    if (state_reg.cnt == frame_last)
                        end_frame = 1'b1; // R7
                    else
                        state_next.cnt = state_reg.cnt + 4'h1;
                end
            end
            ST_START:
            begin
                if (tick)
                begin
                    state_next.st = ST_DATA; // R3
                    state_next.cnt = CNT_ZERO;
                end
            end
            ST_DATA:
            begin
                if (tick)
                begin
                    if (state_reg.cnt == word_last)
                    begin
                        state_next.st = ST_STOP; // R3
                    end
                    else
                    begin
                        state_next.shift = {1'b0, state_reg.shift[8:1]}; // R3
                        state_next.cnt = state_reg.cnt + 4'h1;
                    end
                end
            end
            ST_STOP:
            begin
                if (tick)
                begin
                    set_tc = 1'b1; // R12
                    end_frame = 1'b1;
                end
            end
            ST_BREAK:
            begin
                if (tick)
                begin
                    if (state_reg.cnt != frame_last)
                    begin
                        state_next.cnt = state_reg.cnt + 4'h1; // R21
                    end
                    else if (send_break_ctl_i && tx_enable_i)
                    begin
                        state_next.cnt = CNT_ZERO; // R14
                    end
                    else
                    begin
                        state_next.st = ST_MARK; // R15
                    end
                end
            end
            ST_MARK:
            begin
                if (tick)
                    end_frame = 1'b1; // R15
            end
        endcase

        // frame boundary: choose what the line does next
        if (end_frame)
        begin
            state_next.cnt = CNT_ZERO;
            if (!tx_enable_i)
            begin
                state_next.st = ST_OFF;
            end
            else if (state_reg.pre_pend || en_rise)
            begin
                state_next.st = ST_PRE; // R16
                state_next.pre_pend = 1'b0;
            end
            else if (send_break_ctl_i)
            begin
                state_next.st = ST_BREAK; // R14
            end
            else if (fifo_valid)
            begin
                load = 1'b1; // R10 R11
                state_next.st = ST_START;
                state_next.shift = word9_sel_i ? fifo_data : {1'b0, fifo_data[7:0]}; // R6
                set_tx_buffer_empty_flag = fifo_last; // R9
            end
            else
            begin
                state_next.st = ST_IDLE; // R1
            end
        end

        // line level follows the state being entered
        if (state_next.st == ST_START || state_next.st == ST_BREAK)
            state_next.line = 1'b0; // R4 R21
        else if (state_next.st == ST_DATA)
            state_next.line = state_next.shift[0]; // R3
        else
            state_next.line = 1'b1; // R1 R5
        state_next.oe = state_next.st != ST_OFF; // R2

        // ****************************************
        // flags: set wins over the clearing sequence
        // ****************************************
        clear_seq = serial_data_port_wr_i && state_reg.seen; // R8 R13
        if (clear_seq)
            state_next.seen = 1'b0;
        else if (serial_status_port_rd_i)
            state_next.seen = 1'b1;
        state_next.tx_buffer_empty_flag = set_tx_buffer_empty_flag || (state_reg.tx_buffer_empty_flag && !clear_seq); // R8 R9
        state_next.tc = set_tc || (state_reg.tc && !clear_seq); // R12 R13
        state_next.irq = ((state_next.tx_buffer_empty_flag && tx_empty_irq_en_i)
                         || (state_next.tc && tx_complete_irq_en_i))
                         && (cpu_condition_codes_i == CPU_MASK_OPEN); // R9 R12
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= '0;
            state_reg.st <= ST_OFF;
            state_reg.line <= 1'b1;
            state_reg.tx_buffer_empty_flag <= TX_BUFFER_EMPTY_FLAG_RST;
            state_reg.tc <= TC_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign serial_tx_o = state_reg.line;
    assign serial_tx_oe_o = state_reg.oe;
    assign data_ready_o = fifo_ready;
    assign tx_buffer_empty_flag_o = state_reg.tx_buffer_empty_flag;
    assign tx_complete_flag_o = state_reg.tc;
    assign irq_o = state_reg.irq;

    // ****************************************
    // assertions
    // ****************************************
    AST_IDLE_HIGH: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R1
        (state_reg.st == ST_IDLE) |-> (serial_tx_o && serial_tx_oe_o))
        else $error("idle line not driven high");

    AST_RELEASE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R2
        (state_reg.st == ST_STOP && tick && !tx_enable_i) |=> !serial_tx_oe_o)
        else $error("pin not released after disable");

    AST_START_LOW: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R4
        (state_reg.st == ST_START) |-> (!serial_tx_o && serial_tx_oe_o))
        else $error("start bit not low");

    AST_STOP_AFTER_DATA: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R3
        (state_reg.st == ST_DATA && tick && state_reg.cnt == word_last)
        |=> (state_reg.st == ST_STOP && serial_tx_o))
        else $error("stop bit missing after last data bit");

    AST_PRE_LEN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R7
        (state_reg.st == ST_PRE && tick && state_reg.cnt != frame_last) |=> (state_reg.st == ST_PRE))
        else $error("preamble ended early");

    AST_TC_SET: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R12
        (state_reg.st == ST_STOP && tick) |=> tx_complete_flag_o)
        else $error("complete flag not set after stop bit");

    AST_TC_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R13
        (state_reg.seen && serial_data_port_wr_i && !(state_reg.st == ST_STOP && tick))
        |=> !tx_complete_flag_o)
        else $error("complete flag survived clear sequence");

    AST_BREAK_LOW: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R21
        (state_reg.st == ST_BREAK) |-> !serial_tx_o)
        else $error("break character not low");

    AST_BREAK_MARK: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R15
        (state_reg.st == ST_BREAK && tick && state_reg.cnt == frame_last && !send_break_ctl_i)
        |=> (state_reg.st == ST_MARK && serial_tx_o))
        else $error("no high bit after last break");

    AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R9
        (tx_buffer_empty_flag_o && $past(tx_empty_irq_en_i)
         && $past(cpu_condition_codes_i) == CPU_MASK_OPEN) |-> irq_o)
        else $error("empty interrupt not raised");

endmodule

// ---- verification/ast_line_mon.sv ----
`timescale 1ns/1ps
// ********
// receiving equipment on the serial line
// ********
module ast_line_mon (
    input wire logic ref_clk_i, // system clock
    input wire logic line_i, // resolved pin level
    input wire logic word9_i, // 1 = 9-bit words
    input wire logic [15:0] bit_cyc_i, // cycles per bit
    output logic [8:0] rx_data_o, // last word
    output logic [7:0] rx_cnt_o, // frames seen
    output logic [7:0] bad_cnt_o // framing faults
);
    logic [8:0] w;
    // samples on the falling edge so it never races the design's updates
    initial
    begin
        rx_data_o = 9'h000;
        rx_cnt_o = 8'h00;
        bad_cnt_o = 8'h00;
        w = 9'h000;
        forever
        begin
            @(negedge ref_clk_i iff !line_i);
            repeat (bit_cyc_i / 2) @(negedge ref_clk_i);
            if (line_i)
                bad_cnt_o++;
            w = 9'h000;
            for (int i = 0; i < (word9_i ? 9 : 8); i++)
            begin
                repeat (bit_cyc_i) @(negedge ref_clk_i);
                w[i] = line_i;
            end
            repeat (bit_cyc_i) @(negedge ref_clk_i);
            // a break has no stop bit: resync on the next high level
            if (!line_i)
            begin
                bad_cnt_o++;
                @(negedge ref_clk_i iff line_i);
            end
            rx_data_o = w;
            rx_cnt_o++;
        end
    end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, en = 1'b0, w9 = 1'b0, nb = 1'b0, brk = 1'b0;
    logic tx_empty_irq_en = 1'b0, tx_complete_irq_en = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [1:0] cpu_condition_codes = 2'h0, pr = 2'h0;
    logic [2:0] tr = 3'h0;
    logic [7:0] d = 8'h00, ext = 8'h00;
    logic tx, oe, rdy, tx_buffer_empty_flag, tc, irq, pin;
    logic [15:0] bt = 16'h0010;
    logic [8:0] rxd;
    logic [7:0] rxc, bad, bad_base = 8'h00;
    int err_total = 0, check_count = 0;
    // pull-up stands in for the port when the block lets go of the pin
    assign pin = oe ? tx : 1'b1;
    always #2 clk = ~clk;
    ast_tx #(.DEPTH(16)) ast_tx_i (.ref_clk_i(clk), .nrst_i(nrst), .tx_enable_i(en),
        .word9_sel_i(w9), .tx_ninth_bit_i(nb), .send_break_ctl_i(brk), .tx_empty_irq_en_i(tx_empty_irq_en),
        .tx_complete_irq_en_i(tx_complete_irq_en), .cpu_condition_codes_i(cpu_condition_codes), .serial_status_port_rd_i(rd),
        .serial_data_port_wr_i(wr), .serial_data_port_i(d), .baud_select_pr_i(pr),
        .baud_select_tr_i(tr), .tx_ext_prescaler_i(ext), .serial_tx_o(tx), .serial_tx_oe_o(oe),
        .data_ready_o(rdy), .tx_buffer_empty_flag_o(tx_buffer_empty_flag), .tx_complete_flag_o(tc), .irq_o(irq));
    ast_line_mon ast_line_mon_i (.ref_clk_i(clk), .line_i(pin), .word9_i(w9), .bit_cyc_i(bt),
        .rx_data_o(rxd), .rx_cnt_o(rxc), .bad_cnt_o(bad));
    // ********
    // helpers
    // ********
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic put(input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        d <= v;
        nb <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic stat;
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // counts falling edges while the pin holds lvl; call on a falling edge
    task automatic run(input logic lvl, output int n);
        n = 0;
        while (pin === lvl && n < 40 * bt)
        begin
            n++;
            @(negedge clk);
        end
    endtask
    task automatic rx_wait(input logic [7:0] b, input logic [8:0] e);
        for (int i = 0; i < 40 * bt && rxc === b; i++)
            @(negedge clk);
        chk("frame count", rxc, b + 8'h01);
        chk("word", rxd, e);
        chk("framing", bad, bad_base);
    endtask
    task automatic en_set(input logic v);
        @(posedge clk);
        en <= v;
        for (int i = 0; i < 40 * bt && oe !== v; i++)
            @(negedge clk);
        chk("pin enable", oe, v);
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_pre(input logic m);
        int n;
        logic [7:0] b;
        @(posedge clk);
        w9 <= m;
        b = rxc;
        en_set(1'b1);
        put(8'hA5);
        @(negedge clk);
        run(1'b1, n);
        chk("preamble", n + 6 >= (m ? 11 : 10) * bt && n <= (m ? 11 : 10) * bt + bt / 2, 1'b1);
        rx_wait(b, {m, 8'hA5});
        en_set(1'b0);
    endtask
    task automatic t_flags;
        logic [7:0] b;
        @(posedge clk);
        w9 <= 1'b0;
        tx_empty_irq_en <= 1'b1;
        tx_complete_irq_en <= 1'b1;
        cpu_condition_codes <= 2'h1;
        en_set(1'b1);
        repeat (3) @(negedge clk);
        chk("masked irq", irq, 1'b0);
        @(posedge clk);
        cpu_condition_codes <= 2'h0;
        repeat (3) @(negedge clk);
        chk("irq", irq, 1'b1);
        b = rxc;
        put(8'h3C);
        repeat (3) @(negedge clk);
        chk("flags kept", {tx_buffer_empty_flag, tc}, 2'h3);
        rx_wait(b, 9'h03C);
        repeat (bt) @(negedge clk);
        b = rxc;
        stat;
        put(8'hC3);
        repeat (4) @(negedge clk);
        chk("direct load", {pin, tx_buffer_empty_flag, tc}, 3'h2);
        stat;
        put(8'h5A);
        repeat (3) @(negedge clk);
        chk("held", {tx_buffer_empty_flag, irq}, 2'h0);
        rx_wait(b, 9'h0C3);
        chk("early done", tc, 1'b0);
        // the buffered word moves in only when the stop bit ends
        repeat (bt) @(negedge clk);
        chk("reload", {tx_buffer_empty_flag, tc}, 2'h3);
        rx_wait(b + 8'h01, 9'h05A);
        repeat (bt) @(negedge clk);
        chk("done", {tc, irq}, 2'h3);
    endtask
    task automatic t_fill;
        logic [7:0] q[$];
        logic low;
        logic [7:0] b;
        low = 1'b0;
        b = rxc;
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            wr <= 1'b1;
            d <= 8'h40 + i[7:0];
            @(negedge clk);
            if (rdy)
                q.push_back(8'h40 + i[7:0]);
            else
                low = 1'b1;
        end
        @(posedge clk);
        wr <= 1'b0;
        chk("full", {low, 5'(q.size())}, 6'h31);
        for (int k = 0; k < q.size(); k++)
        begin
            rx_wait(b, {1'b0, q[k]});
            b++;
        end
        chk("drained", rdy, 1'b1);
    endtask
    task automatic t_toggle;
        int n;
        logic [7:0] b;
        b = rxc;
        put(8'h11);
        put(8'h22);
        put(8'h33);
        repeat (3 * bt) @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        en <= 1'b1;
        put(8'h44);
        rx_wait(b, 9'h011);
        @(negedge clk);
        run(1'b1, n);
        chk("gap", n + 3 >= 10 * bt + bt / 2 && n <= 11 * bt, 1'b1);
        rx_wait(b + 8'h01, 9'h044);
    endtask
    task automatic t_break;
        int n;
        @(posedge clk);
        brk <= 1'b1;
        put(8'h66);
        fork
            begin
                repeat (25 * bt) @(posedge clk);
                brk <= 1'b0;
            end
        join_none
        @(negedge clk);
        run(1'b1, n);
        run(1'b0, n);
        chk("break", n, 30 * bt);
        // the monitor counted the break's missing stop bit long before the mark
        bad_base = bad;
        run(1'b1, n);
        chk("mark bit", n, bt);
        rx_wait(rxc, 9'h066);
    endtask
    task automatic t_baud;
        int n;
        logic [7:0] b;
        logic [1:0] ps[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic [2:0] ts[4] = '{3'h1, 3'h0, 3'h0, 3'h2};
        logic [7:0] es[4] = '{8'h00, 8'h02, 8'h00, 8'h03};
        logic [15:0] bs[4] = '{16'h0060, 16'h0080, 16'h00D0, 16'h00C0};
        for (int k = 0; k < 4; k++)
        begin
            en_set(1'b0);
            @(posedge clk);
            pr <= ps[k];
            tr <= ts[k];
            ext <= es[k];
            bt <= bs[k];
            en_set(1'b1);
            b = rxc;
            put(8'h01);
            @(negedge clk);
            run(1'b1, n);
            run(1'b0, n);
            chk("bit time", n, bs[k]);
            rx_wait(b, 9'h001);
        end
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("reset", {tx, oe, tx_buffer_empty_flag, tc, irq}, 5'h16);
        @(posedge clk);
        nrst <= 1'b1;
        t_pre(1'b0);
        t_pre(1'b1);
        t_flags;
        t_fill;
        t_toggle;
        t_break;
        t_baud;
        close_out;
    end
    initial
    begin
        #400000;
        err_total++;
        close_out;
    end
endmodule
